// >>> shared/dmc_consts.svh
// Constants of the dual multiply-accumulate datapath with double coefficient
`ifndef DMC_CONSTS_SVH
`define DMC_CONSTS_SVH

// ----------------------------------------
// Instruction decode
// ----------------------------------------
`define DMC_OPCODE_BYTE      8'hFD
`define DMC_SUBOP_SINGLE     6'h08
`define DMC_SUBOP_DOUBLE     6'h0B
`define DMC_MOD_INC          2'h1
`define DMC_MOD_DEC          2'h2
`define DMC_LONG_STEP        2

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DMC_REG_CTRL         8'h00
`define DMC_REG_STATUS       8'h04
`define DMC_REG_MASK         8'h08
`define DMC_REG_CPTR         8'h0C
`define DMC_REG_RPT          8'h10
`define DMC_REG_ACC_BASE     3'h1

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define DMC_CTRL_FRACTIONAL  0
`define DMC_CTRL_ROUND_METH  1
`define DMC_CTRL_ACC_SAT     2
`define DMC_CTRL_MUL_SAT     3
`define DMC_CTRL_OVF_WIDTH   4
`define DMC_CTRL_W           5
`define DMC_CTRL_RESET       5'h00
`define DMC_STAT_BUSERR      4
`define DMC_STAT_ILLEGAL     5
`define DMC_STAT_W           6
`define DMC_STAT_RESET       6'h00
`define DMC_MASK_RESET       6'h00
`define DMC_ACC_RESET        40'h00_0000_0000

// ----------------------------------------
// Arithmetic constants
// ----------------------------------------
`define DMC_ACC_SHIFT        16
`define DMC_ROUND_HALF       41'h000_0000_8000
`define DMC_ROUND_UNIT       41'h000_0001_0000
`define DMC_ROUND_LOW        16'h8000
`define DMC_MUL_NEG_ONE      17'h1_8000
`define DMC_MUL_SAT          32'h7FFF_FFFF
`define DMC_SAT_POS40        40'h7F_FFFF_FFFF
`define DMC_SAT_NEG40        40'h80_0000_0000
`define DMC_SAT_POS32        40'h00_7FFF_FFFF
`define DMC_SAT_NEG32        40'hFF_8000_0000

`endif

// >>> shared/dmc_pkg.sv
// Types and helpers shared by the dual multiply-accumulate datapath
package dmc_pkg;

  // ----------------------------------------
  // Instruction word, first byte at the top
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] dataAddrMode;
    logic [5:0] subop;
    logic [1:0] ptrMod;
    logic [1:0] xIdx;
    logic [1:0] yIdx;
    logic       dataUns;
    logic       coefUns;
    logic       wide;
    logic       rnd;
  } dmc_instr_t;

  typedef struct packed {
    logic fractional;
    logic roundEn;
    logic roundMethod;
    logic accSat;
    logic mulSat;
    logic wide;
  } dmc_mode_t;

  typedef enum logic {DMC_IDLE, DMC_REPEAT} dmc_state_t;

  // Zero extension when unsigned, sign extension otherwise
  function automatic logic [16:0] dmc_ext17(input logic [15:0] w, input logic uns);
    return {w[15] & ~uns, w};
  endfunction

endpackage

// >>> rtl/dmc_mac_unit.sv
// One multiplier-accumulator: product, fractional shift, accumulate, round, saturate
`timescale 1ns/100ps
`include "dmc_consts.svh"
module dmc_mac_unit (
  // Operands
  input  wire logic [16:0]       dataOp,
  input  wire logic [16:0]       coefOp,
  input  wire logic [39:0]       accIn,
  input  wire dmc_pkg::dmc_mode_t mode,
  // Result
  output logic      [39:0]       result,
  output logic                   overflow
);
  logic signed [33:0] prod;
  logic        [31:0] prod32;
  logic        [40:0] sum;
  logic        [40:0] rounded;
  logic               roundUp;

  always_comb begin
    prod = $signed(dataOp) * $signed(coefOp);
    prod32 = mode.fractional ? {prod[30:0], 1'b0} : prod[31:0];
    // With signed operands, only -1 x -1 in fractional mode leaves the signed range
    if (mode.mulSat && mode.fractional && dataOp == `DMC_MUL_NEG_ONE && coefOp == `DMC_MUL_NEG_ONE) begin
      prod32 = `DMC_MUL_SAT;
    end
    sum = {accIn[39], accIn} + {{9{prod32[31]}}, prod32};
    roundUp = sum[15:0] > `DMC_ROUND_LOW || (sum[15:0] == `DMC_ROUND_LOW && sum[16]);
    rounded = sum;
    if (mode.roundEn) begin
      if (mode.roundMethod) begin
        rounded = {sum[40:16], 16'h0000} + (roundUp ? `DMC_ROUND_UNIT : 41'h000_0000_0000);
      end else begin
        rounded = sum + `DMC_ROUND_HALF;
        rounded[15:0] = 16'h0000;
      end
    end
    if (mode.wide) begin
      overflow = rounded[40] != rounded[39];
    end else begin
      overflow = !(&rounded[40:31] || ~|rounded[40:31]);
    end
    result = rounded[39:0];
    if (overflow && mode.accSat) begin
      if (mode.wide) begin
        result = rounded[40] ? `DMC_SAT_NEG40 : `DMC_SAT_POS40;
      end else begin
        result = rounded[40] ? `DMC_SAT_NEG32 : `DMC_SAT_POS32;
      end
    end
  end
endmodule

// >>> rtl/dmc_coef_addr.sv
// Coefficient pointer and its paired address for long coefficients
`timescale 1ns/100ps
`include "dmc_consts.svh"
module dmc_coef_addr #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Control
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrData,
  input  wire logic              stepEn,
  input  wire logic [1:0]        ptrMod,
  // Addresses
  output logic      [ADDR_W-1:0] coefAddr,
  output logic      [ADDR_W-1:0] pairAddr
);
  logic [ADDR_W-1:0] ptr_q;
  logic [ADDR_W-1:0] ptr_d;

  always_comb begin
    ptr_d = ptr_q;
    if (stepEn && ptrMod == `DMC_MOD_INC) begin
      ptr_d = ptr_q + ADDR_W'(`DMC_LONG_STEP);
    end else if (stepEn && ptrMod == `DMC_MOD_DEC) begin
      ptr_d = ptr_q - ADDR_W'(`DMC_LONG_STEP);
    end else if (wrEn) begin
      ptr_d = wrData;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= '0;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign coefAddr = ptr_q;
  // Even plus one, odd minus one: flip the lowest bit
  assign pairAddr = {ptr_q[ADDR_W-1:1], ~ptr_q[0]};
endmodule

// >>> rtl/dmc_dual_mac.sv
// Dual multiply-accumulate datapath sharing one data word across two MAC units
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`include "dmc_consts.svh"
module dmc_dual_mac #(
  parameter int ADDR_W = 16,
  parameter int RPT_W  = 16
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdData,
  // Instruction issue
  input  wire logic              instValid,
  input  wire logic [31:0]       instWord,
  output logic                   instReady,
  // Operand buses
  input  wire logic              opValid,
  input  wire logic [15:0]       dataReadBus,
  input  wire logic [15:0]       coefDataBus,
  input  wire logic [15:0]       secondCoefDataBus,
  input  wire logic              coefExternal,
  // Coefficient addresses
  output logic      [ADDR_W-1:0] coefAddressBus,
  output logic      [ADDR_W-1:0] coefPairAddress,
  // Completion and interrupt
  output logic                   macDone,
  output logic                   irq
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (ADDR_W < 2 || ADDR_W > 32 || RPT_W < 1 || RPT_W > 32) begin : gCheck
    $error("dmc_dual_mac: ADDR_W must be 2..32 and RPT_W 1..32");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  dmc_pkg::dmc_state_t       state_q;
  dmc_pkg::dmc_instr_t       instr_q;
  dmc_pkg::dmc_instr_t       cur;
  dmc_pkg::dmc_mode_t        mode;
  logic [RPT_W-1:0]          rptCount_q;
  logic [RPT_W-1:0]          remain_q;
  logic [`DMC_CTRL_W-1:0]    ctrl_q;
  logic [`DMC_STAT_W-1:0]    status_q;
  logic [`DMC_STAT_W-1:0]    status_d;
  logic [`DMC_STAT_W-1:0]    mask_q;
  logic [39:0]               acc_q [4];
  logic [31:0]               rdMux;
  logic [31:0]               regRdData_q;
  logic                      macDone_q;

  // ----------------------------------------
  // Decode and issue
  // ----------------------------------------
  logic        isSingle;
  logic        isDouble;
  logic        legal;
  logic        take;
  logic        fire;
  logic        exec;
  logic [16:0] dataOp;
  logic [16:0] coefHiOp;
  logic [16:0] coefLoOp;
  logic [39:0] srcX;
  logic [39:0] srcY;
  logic [39:0] resX;
  logic [39:0] resY;
  logic        ovfX;
  logic        ovfY;

  function automatic logic [39:0] asr16(input logic [39:0] a);
    return {{`DMC_ACC_SHIFT{a[39]}}, a[39:`DMC_ACC_SHIFT]};
  endfunction

  function automatic logic isAcc(input logic [7:0] a);
    return a[7:5] == `DMC_REG_ACC_BASE && a[1:0] == 2'h0;
  endfunction

  always_comb begin
    cur = (state_q == dmc_pkg::DMC_IDLE) ? dmc_pkg::dmc_instr_t'(instWord) : instr_q;
    isSingle = cur.opcode == `DMC_OPCODE_BYTE && cur.subop == `DMC_SUBOP_SINGLE;
    isDouble = cur.opcode == `DMC_OPCODE_BYTE && cur.subop == `DMC_SUBOP_DOUBLE;
    legal = isSingle || isDouble;
  end

  assign instReady = state_q == dmc_pkg::DMC_IDLE;
  assign take = instReady && instValid;
  // Each repeat iteration waits for fresh operands
  assign fire = (take && legal) || (state_q == dmc_pkg::DMC_REPEAT && opValid);
  // External coefficient access is refused, not computed
  assign exec = fire && !coefExternal;

  always_comb begin
    mode.fractional  = ctrl_q[`DMC_CTRL_FRACTIONAL];
    mode.roundEn     = cur.rnd;
    mode.roundMethod = ctrl_q[`DMC_CTRL_ROUND_METH];
    mode.accSat      = ctrl_q[`DMC_CTRL_ACC_SAT];
    mode.mulSat      = ctrl_q[`DMC_CTRL_MUL_SAT];
    mode.wide        = ctrl_q[`DMC_CTRL_OVF_WIDTH] | cur.wide;
  end

  always_comb begin
    dataOp   = dmc_pkg::dmc_ext17(dataReadBus, cur.dataUns);
    coefHiOp = dmc_pkg::dmc_ext17(secondCoefDataBus, cur.coefUns);
    coefLoOp = dmc_pkg::dmc_ext17(coefDataBus, cur.coefUns);
    srcY = isDouble ? asr16(acc_q[cur.yIdx]) : acc_q[cur.yIdx];
    srcX = asr16(acc_q[cur.xIdx]);
  end

  // ----------------------------------------
  // Two MAC units, both in the same cycle
  // ----------------------------------------
  dmc_mac_unit uSecondMac (
    .dataOp   (dataOp),
    .coefOp   (coefHiOp),
    .accIn    (srcY),
    .mode     (mode),
    .result   (resY),
    .overflow (ovfY)
  );

  dmc_mac_unit uFirstMac (
    .dataOp   (dataOp),
    .coefOp   (coefLoOp),
    .accIn    (srcX),
    .mode     (mode),
    .result   (resX),
    .overflow (ovfX)
  );

  dmc_coef_addr #(
    .ADDR_W (ADDR_W)
  ) uCoefAddr (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .wrEn     (regWr && regAddr == `DMC_REG_CPTR),
    .wrData   (regWrData[ADDR_W-1:0]),
    .stepEn   (exec),
    .ptrMod   (cur.ptrMod),
    .coefAddr (coefAddressBus),
    .pairAddr (coefPairAddress)
  );

  // ----------------------------------------
  // Repeat sequencing
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= dmc_pkg::DMC_IDLE;
      remain_q <= '0;
      instr_q  <= '0;
    end else begin
      case (state_q)
        dmc_pkg::DMC_IDLE: begin
          if (take && legal && rptCount_q != '0) begin
            state_q  <= dmc_pkg::DMC_REPEAT;
            remain_q <= rptCount_q;
            instr_q  <= cur;
          end
        end
        dmc_pkg::DMC_REPEAT: begin
          if (opValid) begin
            remain_q <= remain_q - RPT_W'(1);
            if (remain_q == RPT_W'(1)) begin
              state_q <= dmc_pkg::DMC_IDLE;
            end
          end
        end
        default: begin
          state_q <= dmc_pkg::DMC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Accumulators
  // ----------------------------------------
  // Execution beats a same-cycle software write; with equal indices the first
  // accumulator's operation lands last
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 4; i++) begin
        acc_q[i] <= `DMC_ACC_RESET;
      end
    end else begin
      if (regWr && isAcc(regAddr)) begin
        if (regAddr[2]) begin
          acc_q[regAddr[4:3]][39:32] <= regWrData[7:0];
        end else begin
          acc_q[regAddr[4:3]][31:0] <= regWrData;
        end
      end
      if (exec) begin
        acc_q[cur.yIdx] <= resY;
        acc_q[cur.xIdx] <= resX;
      end
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q     <= `DMC_CTRL_RESET;
      mask_q     <= `DMC_MASK_RESET;
      rptCount_q <= '0;
    end else if (regWr) begin
      case (regAddr)
        `DMC_REG_CTRL: ctrl_q     <= regWrData[`DMC_CTRL_W-1:0];
        `DMC_REG_MASK: mask_q     <= regWrData[`DMC_STAT_W-1:0];
        `DMC_REG_RPT:  rptCount_q <= regWrData[RPT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Status and interrupt
  // ----------------------------------------
  always_comb begin
    status_d = status_q;
    if (regWr && regAddr == `DMC_REG_STATUS) begin
      status_d = status_q & ~regWrData[`DMC_STAT_W-1:0];
    end
    // Events set after the clear so a coincident event is kept
    if (exec && ovfY) begin
      status_d[cur.yIdx] = 1'b1;
    end
    if (exec && ovfX) begin
      status_d[cur.xIdx] = 1'b1;
    end
    if (fire && coefExternal) begin
      status_d[`DMC_STAT_BUSERR] = 1'b1;
    end
    if (take && !legal) begin
      status_d[`DMC_STAT_ILLEGAL] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= `DMC_STAT_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdMux = 32'h0000_0000;
    if (isAcc(regAddr)) begin
      rdMux = regAddr[2] ? {24'h00_0000, acc_q[regAddr[4:3]][39:32]} : acc_q[regAddr[4:3]][31:0];
    end else begin
      case (regAddr)
        `DMC_REG_CTRL:   rdMux = 32'(ctrl_q);
        `DMC_REG_STATUS: rdMux = 32'(status_q);
        `DMC_REG_MASK:   rdMux = 32'(mask_q);
        `DMC_REG_CPTR:   rdMux = 32'(coefAddressBus);
        `DMC_REG_RPT:    rdMux = 32'(rptCount_q);
        default:         rdMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData_q <= 32'h0000_0000;
      macDone_q   <= 1'b0;
    end else begin
      regRdData_q <= regRd ? rdMux : 32'h0000_0000;
      macDone_q   <= exec;
    end
  end

  assign regRdData = regRdData_q;
  assign macDone   = macDone_q;
endmodule

// >>> verification/dmc_mem_model.sv
// Memory read buses feeding the dual multiply-accumulate datapath
`timescale 1ns/100ps
module dmc_mem_model #(
  parameter int ADDR_W   = 16,
  parameter int EXT_BASE = 32'h8000
) (
  // Addresses from the datapath
  input  wire logic [ADDR_W-1:0] coefAddressBus,
  input  wire logic [ADDR_W-1:0] coefPairAddress,
  // Data word to present
  input  wire logic [15:0]       dataIn,
  // Read buses
  output logic      [15:0]       dataReadBus,
  output logic      [15:0]       coefDataBus,
  output logic      [15:0]       secondCoefDataBus,
  output logic                   coefExternal
);
  logic [15:0] coefMem [0:15];
  logic        ext;

  assign ext          = coefAddressBus >= ADDR_W'(EXT_BASE);
  assign coefExternal = ext;
  // External space is not wired here, so the buses carry a scrambled word
  assign secondCoefDataBus = ext ? ~coefMem[coefAddressBus[3:0]] : coefMem[coefAddressBus[3:0]];
  assign coefDataBus       = ext ? ~coefMem[coefPairAddress[3:0]] : coefMem[coefPairAddress[3:0]];
  assign dataReadBus       = dataIn;
endmodule

// >>> verification/dmc_dual_mac_chk.sv
// Port checks of the dual multiply-accumulate datapath
`timescale 1ns/100ps
module dmc_dual_mac_chk #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              arst_n,
  // Observed ports
  input wire logic              regWr,
  input wire logic              instValid,
  input wire logic [31:0]       instWord,
  input wire logic              instReady,
  input wire logic              opValid,
  input wire logic              coefExternal,
  input wire logic [ADDR_W-1:0] coefAddressBus,
  input wire logic [ADDR_W-1:0] coefPairAddress,
  input wire logic              macDone
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic fire;
  logic legal;
  logic iter;
  assign fire  = instValid && instReady;
  assign iter  = !instReady && opValid;
  assign legal = instWord[31:24] == 8'hFD && (instWord[15:10] == 6'h08 || instWord[15:10] == 6'h0B);

  a_done_after_fire: assert property (fire && legal && !coefExternal |=> macDone)
    else $error("no completion after an issued instruction");
  a_done_has_cause: assert property (macDone |-> $past(fire) || $past(iter))
    else $error("completion without an issue or iteration");
  a_illegal_no_done: assert property (fire && !legal |=> !macDone)
    else $error("foreign opcode was executed");
  a_pair_address: assert property (coefPairAddress == {coefAddressBus[ADDR_W-1:1], ~coefAddressBus[0]})
    else $error("paired coefficient address wrong");
  a_ptr_step_up: assert property (fire && legal && !coefExternal && instWord[9:8] == 2'h1
    |=> coefAddressBus == $past(coefAddressBus) + ADDR_W'(2))
    else $error("pointer did not advance by two");
  a_ptr_step_down: assert property (fire && legal && !coefExternal && instWord[9:8] == 2'h2
    |=> coefAddressBus == $past(coefAddressBus) - ADDR_W'(2))
    else $error("pointer did not step back by two");
  a_ptr_hold_ext: assert property (fire && coefExternal && !regWr |=> $stable(coefAddressBus))
    else $error("pointer moved on an external access");
  a_repeat_iter_done: assert property (iter && !coefExternal |=> macDone)
    else $error("repeat iteration not completed");
  a_ready_fall_issue: assert property ($fell(instReady) |-> $past(instValid))
    else $error("busy without an issued instruction");

  c_single_form: cover property (fire && instWord[15:10] == 6'h08);
  c_double_form: cover property (fire && instWord[15:10] == 6'h0B);
  c_repeat_iter: cover property (iter);
endmodule

bind dmc_dual_mac dmc_dual_mac_chk #(.ADDR_W(ADDR_W)) chk (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .regWr(regWr),
  .instValid(instValid),
  .instWord(instWord),
  .instReady(instReady),
  .opValid(opValid),
  .coefExternal(coefExternal),
  .coefAddressBus(coefAddressBus),
  .coefPairAddress(coefPairAddress),
  .macDone(macDone)
);

// >>> verification/dmc_dual_mac_bench.sv
// Self-checking bench of the dual multiply-accumulate datapath
`timescale 1ns/100ps
`include "dmc_consts.svh"
module dmc_dual_mac_bench;
  logic        sys_clk, arst_n, regWr, regRd, instValid, instReady, opValid, coefExternal, macDone, irq;
  logic [7:0]  regAddr;
  logic [31:0] regWrData, regRdData, instWord, q;
  logic [15:0] dataIn, dataReadBus, coefDataBus, secondCoefDataBus, coefAddressBus, coefPairAddress;
  logic [39:0] expAcc [0:3];
  logic [5:0]  expStat;
  logic [15:0] expPtr;
  logic [4:0]  ctl;
  int          fails, cmpCount, cycles;

  dmc_dual_mac #(.ADDR_W(16), .RPT_W(16)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .instValid(instValid),
    .instWord(instWord), .instReady(instReady), .opValid(opValid), .dataReadBus(dataReadBus),
    .coefDataBus(coefDataBus), .secondCoefDataBus(secondCoefDataBus), .coefExternal(coefExternal),
    .coefAddressBus(coefAddressBus), .coefPairAddress(coefPairAddress), .macDone(macDone), .irq(irq));
  dmc_mem_model #(.ADDR_W(16)) mdl (.coefAddressBus(coefAddressBus), .coefPairAddress(coefPairAddress),
    .dataIn(dataIn), .dataReadBus(dataReadBus), .coefDataBus(coefDataBus),
    .secondCoefDataBus(secondCoefDataBus), .coefExternal(coefExternal));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Bus tasks and reference arithmetic
  // ----------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    d = regRdData;
  endtask
  task automatic setAcc(input int n, input logic [39:0] v);
    wr(8'h20 + 8'(8 * n), v[31:0]);
    wr(8'h24 + 8'(8 * n), {24'h00_0000, v[39:32]});
    expAcc[n] = v;
  endtask
  task automatic checkAll(input string name);
    logic [31:0] hi;
    for (int n = 0; n < 4; n++) begin
      rd(8'h20 + 8'(8 * n), q);
      rd(8'h24 + 8'(8 * n), hi);
      chk({hi[7:0], q}, expAcc[n]);
    end
    rd(`DMC_REG_STATUS, q);
    chk({8'h00, q}, {34'h0_0000_0000, expStat});
    rd(`DMC_REG_CPTR, q);
    chk({8'h00, q}, {24'h00_0000, expPtr});
    wr(`DMC_REG_STATUS, 32'h0000_003F);
    expStat = 6'h00;
    $display("Test %s done", name);
  endtask
  function automatic logic [39:0] macRef(input logic [39:0] acc, input logic [15:0] d, c,
                                         input logic dU, cU, sh, rn, wd, output logic ov);
    logic signed [16:0] a, b;
    logic signed [34:0] p;
    logic [31:0]        p32;
    logic [40:0]        s;
    logic               w40;
    a = {d[15] & ~dU, d};
    b = {c[15] & ~cU, c};
    p = a * b;
    if (ctl[0]) p = p <<< 1;
    p32 = p[31:0];
    if (ctl[0] && ctl[3] && a == 17'h1_8000 && b == 17'h1_8000) p32 = 32'h7FFF_FFFF;
    s = (sh ? {{17{acc[39]}}, acc[39:16]} : {acc[39], acc}) + {{9{p32[31]}}, p32};
    if (rn) begin
      if (!(ctl[1] && s[15:0] == 16'h8000 && !s[16])) s = s + 41'h000_0000_8000;
      s[15:0] = 16'h0000;
    end
    w40 = wd | ctl[4];
    ov = w40 ? s[40] != s[39] : !(&s[40:31] || ~|s[40:31]);
    if (ov && ctl[2]) return w40 ? (s[40] ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF)
                                 : (s[40] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF);
    return s[39:0];
  endfunction
  // Issue one instruction, then rptN repeat iterations
  task automatic exec(input logic [31:0] w, input logic [15:0] d, input int rptN);
    logic o, legal;
    legal = w[31:24] == 8'hFD && (w[15:10] == 6'h08 || w[15:10] == 6'h0B);
    @(posedge sys_clk);
    instValid <= 1'b1;
    instWord  <= w;
    dataIn    <= d;
    @(posedge sys_clk);
    instValid <= 1'b0;
    opValid   <= rptN != 0;
    for (int i = 0; i <= rptN; i++) begin
      if (!legal) expStat[5] = 1'b1;
      else if (expPtr >= 16'h8000) expStat[4] = 1'b1;
      else begin
        expAcc[w[7:6]] = macRef(expAcc[w[7:6]], d, mdl.coefMem[{expPtr[3:1], ~expPtr[0]}],
                                w[3], w[2], 1'b1, w[0], w[1], o);
        expStat[w[7:6]] |= o;
        expAcc[w[5:4]] = macRef(expAcc[w[5:4]], d, mdl.coefMem[expPtr[3:0]],
                                w[3], w[2], w[15:10] == 6'h0B, w[0], w[1], o);
        expStat[w[5:4]] |= o;
        expPtr += w[9:8] == 2'h1 ? 16'h0002 : (w[9:8] == 2'h2 ? 16'hFFFE : 16'h0000);
      end
    end
    #1;
    chk(instReady, rptN == 0);
    repeat (rptN) @(posedge sys_clk);
    opValid <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {arst_n, regWr, regRd, instValid, opValid} = 5'h00;
    {regAddr, regWrData, instWord, dataIn} = 88'h0;
    {fails, cmpCount, cycles} = 96'h0;
    {expStat, expPtr, ctl} = 27'h0;
    for (int i = 0; i < 16; i++) mdl.coefMem[i] = 16'h8000;
    mdl.coefMem[1] = 16'h4000;
    mdl.coefMem[2] = 16'h4000;
    mdl.coefMem[3] = 16'h1234;
    for (int i = 0; i < 4; i++) expAcc[i] = 40'h00_0000_0000;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    checkAll("reset");
    setAcc(0, 40'h00_0000_8000);
    setAcc(1, 40'h00_0000_8000);
    exec({8'hFD, 8'h00, 6'h08, 2'h1, 2'h0, 2'h1, 4'hC}, 16'hFE00, 0);
    checkAll("single");
    setAcc(2, 40'h12_3456_8000);
    setAcc(3, 40'hF0_0000_7FFF);
    for (int m = 0; m < 2; m++) begin
      ctl = {3'h0, m[0], 1'b1};
      wr(`DMC_REG_CTRL, {27'h0, ctl});
      // Step up then back down, so the pointer returns to where it started
      exec({8'hFD, 8'h00, 6'h0B, m[0], ~m[0], 2'h2, 2'h3, 4'h1}, 16'hA001, 0);
      checkAll("double");
    end
    ctl = 5'h04;
    wr(`DMC_REG_CTRL, 32'h0000_0004);
    wr(`DMC_REG_MASK, 32'h0000_0001);
    for (int w = 0; w < 2; w++) begin
      setAcc(0, 40'h00_7FFF_FFF0);
      exec({8'hFD, 8'h00, 6'h08, 2'h0, 2'h1, 2'h0, 2'h0, w[0], 1'b0}, 16'h4000, 0);
      chk(irq, w == 0);
      checkAll("overflow");
      // The clearing write lands on the edge just passed
      @(negedge sys_clk);
      chk(irq, 0);
    end
    rd(`DMC_REG_CTRL, q);
    chk({8'h00, q}, 40'h00_0000_0004);
    ctl = 5'h09;
    wr(`DMC_REG_CTRL, 32'h0000_0009);
    wr(`DMC_REG_CPTR, 32'h0000_0004);
    expPtr = 16'h0004;
    wr(`DMC_REG_RPT, 32'h0000_0002);
    exec({8'hFD, 8'h00, 6'h08, 2'h1, 2'h2, 2'h3, 4'h0}, 16'h8000, 2);
    wr(`DMC_REG_RPT, 32'h0000_0000);
    checkAll("repeat");
    wr(`DMC_REG_CPTR, 32'h0000_8000);
    expPtr = 16'h8000;
    exec({8'hFD, 8'h00, 6'h08, 2'h1, 2'h0, 2'h1, 4'h0}, 16'h1111, 0);
    checkAll("external");
    wr(`DMC_REG_CPTR, 32'h0000_0000);
    expPtr = 16'h0000;
    exec({8'hFC, 8'h00, 6'h08, 2'h1, 2'h0, 2'h1, 4'h0}, 16'h1111, 0);
    checkAll("illegal");
    rd(8'hFC, q);
    chk({8'h00, q}, 40'h00_0000_0000);
    wrap_up();
  end
endmodule
